// File: bus_host.sv
// External bus host: drives a programmable peripheral through its bus pins.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "bus_host_defs.svh"
module bus_host
    import bus_host_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  low_lines_out,
    output logic      [7:0]  low_lines_oe,
    input  wire logic [7:0]  low_lines_in,
    output logic      [7:0]  high_lines_out,
    output logic      [7:0]  high_lines_oe,
    input  wire logic [7:0]  high_lines_in,
    output logic      [7:0]  first_port_out,
    output logic      [7:0]  first_port_oe,
    input  wire logic [7:0]  first_port_in,
    output logic      [7:0]  second_port_out,
    output logic      [7:0]  second_port_oe,
    input  wire logic [7:0]  second_port_in,
    output logic      [2:0]  third_port_pins,
    output logic             bit19_or_select_input,
    output logic             address_latch_strobe,
    output logic             high_byte_enable_n,
    output logic             read_n,
    output logic             write_n
);
    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [31:0]  ctrl_reg;
    logic [19:0]  addr_reg;
    logic [15:0]  wdata_reg;
    logic [15:0]  rdata_reg;
    logic         busy_reg;
    logic         go_reg;
    logic         dir_rd_reg;
    cycle_state_e state_reg;
    logic [15:0]  bus_in_s1_reg;
    logic [15:0]  bus_in_s2_reg;
    logic [15:0]  data_in_s1_reg;
    logic [15:0]  data_in_s2_reg;
    logic         tick;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire bus_mode_e mode     = bus_mode_e'(ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    wire logic      muxed    = (mode == MODE_MUX8) || (mode == MODE_MUX16);
    wire logic      wide     = (mode == MODE_MUX16) || (mode == MODE_NMUX16);
    wire logic      ale_pol  = ctrl_reg[`CTRL_ALE_POL];
    wire logic      hbe_n    = ctrl_reg[`CTRL_HBE_N];
    wire logic      acc      = psel && penable;
    wire logic      wr_acc   = acc && pwrite;
    wire logic      sel_ctrl = (paddr == `REG_CTRL);
    wire logic      sel_addr = (paddr == `REG_ADDR);
    wire logic      sel_wdat = (paddr == `REG_WDATA);
    wire logic      sel_rdat = (paddr == `REG_RDATA);
    wire logic      sel_stat = (paddr == `REG_STATUS);
    wire logic      sel_pb   = (paddr == `REG_PORTB);
    wire logic      mapped   = sel_ctrl | sel_addr | sel_wdat | sel_rdat | sel_stat | sel_pb;
    wire logic      start    = wr_acc && sel_addr && !busy_reg;
    wire logic [31:0] rd_mux = sel_ctrl ? ctrl_reg :
                               sel_addr ? {12'h000, addr_reg} :
                               sel_wdat ? {16'h0000, wdata_reg} :
                               sel_rdat ? {16'h0000, rdata_reg} :
                               sel_stat ? {31'h0000_0000, busy_reg} :
                               sel_pb   ? {24'h00_0000, data_in_s2_reg[15:8]} : 32'h0000_0000;
    // Captured data: mux modes read shared lines, non-mux read the ports.
    wire logic [15:0] cap    = muxed ? bus_in_s2_reg : data_in_s2_reg;
    wire logic        drv_wr = (state_reg == ST_DATA) && !dir_rd_reg;

    // ------------------------------------------------------------------------
    // APB slave: one wait-free access, writes take effect at the access edge
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `CTRL_RESET;
            addr_reg   <= 20'h00000;
            wdata_reg  <= 16'h0000;
            dir_rd_reg <= 1'b0;
            go_reg     <= 1'b0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= rd_mux;
            go_reg  <= start;
            if (wr_acc && sel_ctrl && !busy_reg) ctrl_reg <= pwdata;
            if (wr_acc && sel_wdat) wdata_reg <= pwdata[15:0];
            if (start) begin
                addr_reg   <= pwdata[19:0];
                dir_rd_reg <= pwdata[31];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input synchronisers for the pins that the device drives
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_in_s1_reg  <= 16'h0000;
            bus_in_s2_reg  <= 16'h0000;
            data_in_s1_reg <= 16'h0000;
            data_in_s2_reg <= 16'h0000;
        end else begin
            bus_in_s1_reg  <= {high_lines_in, low_lines_in};
            bus_in_s2_reg  <= bus_in_s1_reg;
            data_in_s1_reg <= {second_port_in, first_port_in};
            data_in_s2_reg <= data_in_s1_reg;
        end
    end

    phase_timer #(
        .COUNT (`PHASE_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (busy_reg && !go_reg),
        .tick    (tick)
    );

    // ------------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (go_reg) begin
                    state_reg <= ST_ADDR;
                    busy_reg  <= 1'b1;
                end
                ST_ADDR:  if (tick) state_reg <= ST_LATCH;
                ST_LATCH: if (tick) state_reg <= ST_DATA;
                ST_DATA:  if (tick) state_reg <= ST_DONE;
                ST_DONE: if (tick) begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                    // The synchroniser runs two cycles behind the pins, so what it shows now was seen
                    // while the read strobe was still low; taken one cycle earlier it would show the lines as they were before the strobe fell.
                    if (dir_rd_reg) rdata_reg <= wide && !hbe_n ? cap : {8'h00, cap[7:0]};
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    wire logic in_addr  = (state_reg == ST_ADDR) || (state_reg == ST_LATCH);
    wire logic in_cycle = busy_reg && (state_reg != ST_IDLE);
    wire logic hi_data  = muxed && wide;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_lines_out         <= 8'h00;
            low_lines_oe          <= 8'h00;
            high_lines_out        <= 8'h00;
            high_lines_oe         <= 8'h00;
            first_port_out        <= 8'h00;
            first_port_oe         <= 8'h00;
            second_port_out       <= 8'h00;
            second_port_oe        <= 8'h00;
            third_port_pins       <= 3'h0;
            bit19_or_select_input <= 1'b1;
            address_latch_strobe  <= 1'b0;
            high_byte_enable_n    <= 1'b1;
            read_n                <= 1'b1;
            write_n               <= 1'b1;
        end else begin
            // Strobe active only in the address phase; the address stays through its trailing edge.
            address_latch_strobe <= (state_reg == ST_ADDR) ? ale_pol : ~ale_pol;
            // The third port is only ever an address input here; its single-term outputs stay unused.
            third_port_pins      <= addr_reg[18:16];
            bit19_or_select_input <= ctrl_reg[`CTRL_CS_ACT] ? ~in_cycle : addr_reg[19];
            high_byte_enable_n   <= in_cycle ? hbe_n : 1'b1;
            read_n               <= !((state_reg == ST_DATA) && dir_rd_reg);
            write_n              <= !drv_wr;
            if (muxed) begin
                // Address out then data (writes) or release (reads) on shared lines.
                low_lines_out  <= in_addr ? addr_reg[7:0] : wdata_reg[7:0];
                low_lines_oe   <= (in_addr || drv_wr) ? 8'hFF : 8'h00;
                high_lines_out <= (in_addr || !hi_data) ? addr_reg[15:8] : wdata_reg[15:8];
                high_lines_oe  <= (in_addr || !hi_data || drv_wr) ? 8'hFF : 8'h00;
                first_port_oe  <= 8'h00;
            end else begin
                low_lines_out  <= addr_reg[7:0];
                low_lines_oe   <= 8'hFF;
                high_lines_out <= addr_reg[15:8];
                high_lines_oe  <= 8'hFF;
                first_port_out <= wdata_reg[7:0];
                first_port_oe  <= drv_wr ? 8'hFF : 8'h00;
            end
            if (mode == MODE_NMUX16) begin
                second_port_out <= wdata_reg[15:8];
                second_port_oe  <= (drv_wr && !hbe_n) ? 8'hFF : 8'h00;
            end else begin
                second_port_oe  <= 8'h00;
            end
        end
    end
endmodule // bus_host

// File: bus_host_defs.svh
// Constants for the external bus host controller.
`ifndef BUS_HOST_DEFS_SVH
`define BUS_HOST_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CTRL       12'h000
`define REG_ADDR       12'h004
`define REG_WDATA      12'h008
`define REG_RDATA      12'h00C
`define REG_STATUS     12'h010
`define REG_PORTB      12'h014
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  1
`define CTRL_ALE_POL   2
`define CTRL_CS_ACT    3
`define CTRL_HBE_N     4
`define CTRL_RESET     32'h0000_0000
// ----------------------------------------------------------------------------
// Timing: each bus phase lasts this many pclk cycles, the address phase one cycle more
// ----------------------------------------------------------------------------
`define PHASE_NS       200
`define CLK_NS         100
`define PHASE_CYCLES   ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: bus_host_pkg.sv
// Types for the external bus host controller.
package bus_host_pkg;
    typedef enum logic [1:0] {
        MODE_MUX8    = 2'h0,
        MODE_MUX16   = 2'h1,
        MODE_NMUX8   = 2'h2,
        MODE_NMUX16  = 2'h3
    } bus_mode_e;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_LATCH = 5'h04,
        ST_DATA  = 5'h08,
        ST_DONE  = 5'h10
    } cycle_state_e;
endpackage

// File: phase_timer.sv
// Phase timer: one-cycle enable pulse every given number of clocks.
`timescale 1ns/1ps
module phase_timer #(
    parameter int unsigned COUNT = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      tick
);
    logic [7:0] cnt_reg;
    wire  [7:0] last = 8'(COUNT - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            tick    <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 8'h00;
            tick    <= 1'b0;
        end else begin
            tick    <= (cnt_reg == last);
            cnt_reg <= (cnt_reg == last) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
endmodule // phase_timer

// File: periph_model.sv
// Behavioural model of the programmable peripheral behind the bus host.
`timescale 1ns/1ps
module periph_model (
    input  wire logic       pclk,
    input  wire logic       strobe,
    input  wire logic       hbe_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       b19,
    input  wire logic [1:0] mode,
    input  wire logic [2:0] tp,
    input  wire logic [7:0] lo_o,
    input  wire logic [7:0] lo_e,
    input  wire logic [7:0] hi_o,
    input  wire logic [7:0] hi_e,
    input  wire logic [7:0] fp_o,
    input  wire logic [7:0] fp_e,
    input  wire logic [7:0] sp_o,
    input  wire logic [7:0] sp_e,
    output logic      [7:0] lo_i,
    output logic      [7:0] hi_i,
    output logic      [7:0] fp_i,
    output logic      [7:0] sp_i
);
    logic [15:0] mem [0:15];
    logic [19:0] lat, cur, last_addr;
    logic [15:0] dout;
    logic [7:0]  pat = 8'h5A;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // Released lines toggle every cycle, so a stale value never passes for data.
    always @(posedge pclk) pat <= ~pat;
    // The strobe is taken as active high; its trailing edge holds the address.
    always @(negedge strobe) lat <= {b19, tp, hi_o, lo_o};
    assign cur = mode[1] ? {b19, tp, hi_o, lo_o} : {lat[19:16], mode[0] ? lat[15:8] : hi_o, lat[7:0]};
    assign dout = mem[cur[3:0]];
    function automatic logic [7:0] pin(input logic [7:0] o, e, d, input logic de, input logic [7:0] p);
        return (o & e) | (~e & (de ? d : p));
    endfunction
    assign lo_i = pin(lo_o, lo_e, dout[7:0], !rd_n && !mode[1], pat);
    assign hi_i = pin(hi_o, hi_e, dout[15:8], !rd_n && mode == 2'h1 && !hbe_n, pat);
    assign fp_i = pin(fp_o, fp_e, dout[7:0], !rd_n && mode[1], ~pat);
    assign sp_i = pin(sp_o, sp_e, dout[15:8], !rd_n && mode == 2'h3 && !hbe_n, ~pat);
    always @(posedge pclk) begin
        if (!wr_n) begin
            mem[cur[3:0]][7:0] <= mode[1] ? fp_i : lo_i;
            if (mode[0] && !hbe_n) mem[cur[3:0]][15:8] <= mode[1] ? sp_i : hi_i;
        end
        if (!wr_n || !rd_n) last_addr <= cur;
    end
endmodule // periph_model

// File: bus_host_sva.sv
// Port assertions for the bus host.
`timescale 1ns/1ps
module bus_host_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       read_n,
    input wire logic       write_n,
    input wire logic       address_latch_strobe,
    input wire logic       high_byte_enable_n,
    input wire logic [7:0] low_lines_out,
    input wire logic [7:0] low_lines_oe,
    input wire logic [7:0] high_lines_out,
    input wire logic [7:0] first_port_oe,
    input wire logic [7:0] second_port_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_ready_access: assert property (psel && !penable |=> pready) else $error("no pready");
    a_rw_excl: assert property (!(!read_n && !write_n)) else $error("read and write");
    a_rd_release: assert property (!read_n |-> (first_port_oe | second_port_oe) == 8'h00)
        else $error("port driven in read");
    a_wr_drive: assert property (!write_n |-> (low_lines_oe | first_port_oe) != 8'h00)
        else $error("no write data");
    a_hbe_gate: assert property (high_byte_enable_n |-> second_port_oe == 8'h00)
        else $error("high byte driven");
    // Only the active-high strobe setting makes the falling edge the trailing one.
    a_addr_hold: assert property ($fell(address_latch_strobe) |-> $stable(low_lines_out)
        && $stable(high_lines_out)) else $error("address moved");
    a_wr_phase: assert property ($fell(write_n) |=> !write_n) else $error("short write");
    c_write: cover property ($fell(write_n));
    c_wide_read: cover property (!read_n && !high_byte_enable_n);
    c_error: cover property (pslverr);
endmodule // bus_host_sva
bind bus_host bus_host_sva bus_host_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .read_n(read_n), .write_n(write_n),
    .address_latch_strobe(address_latch_strobe), .high_byte_enable_n(high_byte_enable_n),
    .low_lines_out(low_lines_out), .low_lines_oe(low_lines_oe), .high_lines_out(high_lines_out),
    .first_port_oe(first_port_oe), .second_port_oe(second_port_oe));

// File: bus_host_tb.sv
// Self-checking bench: bus host against the peripheral model.
`timescale 1ns/1ps
`include "bus_host_defs.svh"
module bus_host_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [1:0]  mode_cfg = 2'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, strobe, hbe_n, rd_n, wr_n, b19;
    wire  [7:0]  lo_o, lo_e, lo_i, hi_o, hi_e, hi_i, fp_o, fp_e, fp_i, sp_o, sp_e, sp_i;
    wire  [2:0]  tp;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;
    bus_host bus_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_lines_out(lo_o), .low_lines_oe(lo_e), .low_lines_in(lo_i), .high_lines_out(hi_o),
        .high_lines_oe(hi_e), .high_lines_in(hi_i), .first_port_out(fp_o), .first_port_oe(fp_e),
        .first_port_in(fp_i), .second_port_out(sp_o), .second_port_oe(sp_e), .second_port_in(sp_i),
        .third_port_pins(tp), .bit19_or_select_input(b19), .address_latch_strobe(strobe),
        .high_byte_enable_n(hbe_n), .read_n(rd_n), .write_n(wr_n));
    periph_model periph_model_inst (.pclk(pclk), .strobe(strobe), .hbe_n(hbe_n), .rd_n(rd_n), .wr_n(wr_n),
        .b19(b19), .mode(mode_cfg), .tp(tp), .lo_o(lo_o), .lo_e(lo_e), .hi_o(hi_o), .hi_e(hi_e),
        .fp_o(fp_o), .fp_e(fp_e), .sp_o(sp_o), .sp_e(sp_e), .lo_i(lo_i), .hi_i(hi_i), .fp_i(fp_i), .sp_i(sp_i));
    // ------------------------------------------------------------------------
    // Clock, bus tasks and expectations
    // ------------------------------------------------------------------------
    initial forever #50 pclk = ~pclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A second start right behind the first must be ignored while busy.
    task automatic bus(input logic [31:0] cmd);
        logic [31:0] q;
        logic        e;
        apb(1'b1, `REG_ADDR, cmd, q, e);
        apb(1'b1, `REG_ADDR, cmd ^ 32'h0000_0001, q, e);
        do apb(1'b0, `REG_STATUS, 32'h0000_0000, q, e); while (q[0] !== 1'b0);
    endtask
    function automatic logic [15:0] after_wr(input logic [1:0] m, input logic hoff, input logic [15:0] old, nw);
        return (m[0] && !hoff) ? nw : {old[15:8], nw[7:0]};
    endfunction
    function automatic logic [31:0] rd_mask(input logic [1:0] m);
        return m[0] ? 32'h0000_FFFF : 32'h0000_00FF;
    endfunction
    initial begin
        logic [31:0] q;
        logic        e;
        logic [19:0] a;
        logic [15:0] wd;
        logic [15:0] ref_mem [0:15];
        logic [1:0]  m;
        logic        hoff;
        logic        cs;
        foreach (ref_mem[i]) ref_mem[i] = 16'h0000;
        q = $urandom(32'hF1D2);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 12'hFFC, 32'h0000_0000, q, e);
        chk("unmapped error", 32'h0000_0001, 32'(e));
        for (int i = 0; i < 24; i++) begin
            m = i[1:0];
            hoff = i[2];
            cs = i[4];
            a = (i < 8) ? {20{i[0]}} : 20'($urandom);
            wd = 16'($urandom);
            mode_cfg <= m;
            apb(1'b1, `REG_CTRL, {27'h0, hoff, cs, 1'b1, m}, q, e);
            apb(1'b1, `REG_WDATA, {16'h0000, wd}, q, e);
            bus({12'h000, a});
            chk("held address", {12'h000, cs ? 1'b0 : a[19], a[18:0]}, {12'h000, periph_model_inst.last_addr});
            ref_mem[a[3:0]] = after_wr(m, hoff, ref_mem[a[3:0]], wd);
            apb(1'b1, `REG_CTRL, {27'h0, 1'b0, 2'b01, m}, q, e);
            bus({12'h800, a});
            apb(1'b0, `REG_RDATA, 32'h0000_0000, q, e);
            chk("read data", {16'h0000, ref_mem[a[3:0]]} & rd_mask(m), q & rd_mask(m));
            $display("test %0d mode %0d done", i, m);
        end
        finish_test();
    end
endmodule // bus_host_tb
